// ===== ups_pkg.sv
// Package with register map, field positions and timing constants of the status block.
package ups_pkg;

  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] BUS_STATUS_CONTROL_OFS   = 8'h1a;
  localparam logic [7:0] ENDPOINT_FLAGS_OFS       = 8'h1b;
  localparam logic [7:0] SYSTEM_CLOCK_CONTROL_OFS = 8'h1c;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int BSC_SUSPEND   = 0;
  localparam int BSC_WAKEUP    = 1;
  localparam int BSC_RESET     = 2;
  localparam int BSC_RESUME    = 3;
  localparam int BSC_DATA_IN   = 4;
  localparam int BSC_CLOCK_IN  = 5;
  localparam int BSC_DATA_OUT  = 6;
  localparam int BSC_CLOCK_OUT = 7;
  localparam int EPF_REQ_LO    = 0;
  localparam int EPF_LEGACY    = 4;
  localparam int EPF_SERIAL    = 5;
  localparam int EPF_MARKER    = 7;
  localparam int SCC_CLK_GATE  = 3;
  localparam int SCC_DEEP_SUSP = 4;
  localparam int SCC_OSC_RATE  = 6;
  localparam int SCC_MARKER    = 7;
  localparam int NUM_EP        = 3;

  // Bits that firmware may write; reserved bits are held at zero.
  localparam logic [7:0] EPF_WMASK = 8'hb7;
  localparam logic [7:0] SCC_WMASK = 8'hd8;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic       KBD_LINE_RST = 1'b1;
  localparam logic [7:0] EPF_RST      = 8'h00;
  localparam logic [7:0] SCC_RST      = 8'h00;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_HZ        = 50000000;
  localparam int IDLE_MS       = 3;
  localparam int IDLE_CYCLES   = (CLK_HZ / 1000) * IDLE_MS;

  // Register bus request carried as one bundle.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ups_req_t;

  // Events reported by the bus front end.
  typedef struct packed {
    logic               bus_active;
    logic               bus_reset;
    logic               resume;
    logic [NUM_EP-1:0]  ep_access;
  } ups_evt_t;

endpackage

// ===== ups_status_ctrl.sv
// Status, control and clock-select register bank of the serial bus and keyboard-port block.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// R1 - Bus status bit 0 is read-only and reads 1 while suspended.
// R2 - Bus status bit 1 is write-only remote wake-up drive, reset 0.
// R3 - Bus status bit 2 is a readable, writable bus reset flag, reset 0.
// R4 - Bus status bit 3 is read-only, set on host resume, reset 0.
// R5 - Bus status bits 6 and 7 are write-only port line drives, reset 1.
// R6 - Endpoint access sets its request flag and raises the interrupt if allowed.
// R7 - Firmware clears a serviced flag; an access while the flag is 1 is dropped, not held.
// R8 - Firmware writes 0 to reserved endpoint register bits 3 and 6.
// R9 - Endpoint register bit 4 selects legacy port operation, reset 0.
// R10 - Endpoint register bit 5 selects serial bus operation, reset 0.
// R11 - Endpoint register bit 7 is a firmware bus-mode marker, reset 0.
// R12 - Clock register bit 3 gates the bus clock, reset 0.
// R13 - Clock register bit 4 is deep suspend; never set in serial bus mode.
// R14 - Clock register bit 6 picks 12 MHz at 0, 6 MHz at 1, reset 0.
// R15 - Clock register bit 7 is a firmware legacy-port marker, reset 0.
// R16 - Firmware writes 0 to reserved clock register bits 0 to 2 and 5.
// R17 - Legacy select alone routes pins to port lines; serial select to engine.
// R18 - Bits 4 and 5 read pin levels, gated by their output bits.
// R19 - Over 3 ms without bus activity sets suspend and raises the interrupt.
// R20 - Hardware sets the bus reset flag; it holds until firmware writes 0.
module ups_status_ctrl #(
  parameter int IDLE_CYCLES = ups_pkg::IDLE_CYCLES
) (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire ups_pkg::ups_req_t           req,
  output logic [7:0]                       rdata,
  input  wire ups_pkg::ups_evt_t           evt,
  input  wire logic                        irq_enable,
  input  wire logic                        stack_full,
  output logic                             bus_irq,
  output logic                             remote_wakeup_drive,
  input  wire logic                        kbd_data_pin_in,
  input  wire logic                        kbd_clock_pin_in,
  output logic                             kbd_data_oe,
  output logic                             kbd_clock_oe,
  output logic                             kbd_data_pin_out,
  output logic                             kbd_clock_pin_out,
  output logic                             engine_owns_pins,
  output logic                             bus_clock_gate,
  output logic                             deep_suspend,
  output logic                             oscillator_rate_select
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] dat_s1_q;
  logic [1:0] dat_s2_q;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      dat_s1_q <= 2'h0;
      dat_s2_q <= 2'h0;
    end
    else
    begin
      dat_s1_q <= {kbd_clock_pin_in, kbd_data_pin_in};
      dat_s2_q <= dat_s1_q;
    end
  end

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  wire wr_bsc = req.wr && (req.addr == ups_pkg::BUS_STATUS_CONTROL_OFS);
  wire wr_epf = req.wr && (req.addr == ups_pkg::ENDPOINT_FLAGS_OFS);
  wire wr_scc = req.wr && (req.addr == ups_pkg::SYSTEM_CLOCK_CONTROL_OFS);

  // --------------------------------------------------------------------------
  // Bus status and control
  // --------------------------------------------------------------------------
  logic        suspend_q;
  logic        wakeup_q;
  logic        reset_flag_q;
  logic        resume_q;
  logic        data_out_q;
  logic        clock_out_q;
  logic [31:0] idle_cnt_q;
  logic [31:0] idle_cnt_d;

  wire idle_done = (idle_cnt_q >= 32'(IDLE_CYCLES));
  wire suspend_d = !evt.bus_active && (idle_done || suspend_q);       // see R19
  wire suspend_rise = suspend_d && !suspend_q;

  assign idle_cnt_d = evt.bus_active ? 32'h0 :
                      (idle_done ? idle_cnt_q : idle_cnt_q + 32'h1);

  // A new bus reset beats a firmware clear in the same cycle.
  wire reset_flag_d = evt.bus_reset ? 1'b1 :                          // see R20
                      (wr_bsc ? req.wdata[ups_pkg::BSC_RESET] : reset_flag_q); // see R3

  // Resume is cleared in any cycle with bus activity and no new resume.
  wire resume_d = evt.resume ? 1'b1 :                                 // see R4
                  ((evt.bus_active && !evt.resume) ? 1'b0 : resume_q);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      suspend_q    <= 1'b0;
      wakeup_q     <= 1'b0;
      reset_flag_q <= 1'b0;
      resume_q     <= 1'b0;
      data_out_q   <= ups_pkg::KBD_LINE_RST;
      clock_out_q  <= ups_pkg::KBD_LINE_RST;
      idle_cnt_q   <= 32'h0;
    end
    else
    begin
      suspend_q    <= suspend_d;                                      // see R1
      reset_flag_q <= reset_flag_d;
      resume_q     <= resume_d;
      idle_cnt_q   <= idle_cnt_d;
      if (wr_bsc)
      begin
        wakeup_q    <= req.wdata[ups_pkg::BSC_WAKEUP];                // see R2
        data_out_q  <= req.wdata[ups_pkg::BSC_DATA_OUT];              // see R5
        clock_out_q <= req.wdata[ups_pkg::BSC_CLOCK_OUT];             // see R5
      end
    end
  end

  // --------------------------------------------------------------------------
  // Endpoint flags and interface select
  // --------------------------------------------------------------------------
  logic [7:0] epf_q;
  logic [ups_pkg::NUM_EP-1:0] req_flags;
  logic [ups_pkg::NUM_EP-1:0] req_set;
  logic [ups_pkg::NUM_EP-1:0] req_next;
  logic [ups_pkg::NUM_EP-1:0] req_kept;
  logic [7:0] epf_d;

  assign req_flags = epf_q[ups_pkg::EPF_REQ_LO +: ups_pkg::NUM_EP];
  // Flags as firmware leaves them in this cycle, before any new access.
  assign req_kept = wr_epf ? req.wdata[ups_pkg::EPF_REQ_LO +: ups_pkg::NUM_EP] : req_flags;
  // An access is taken only while its flag is clear, or cleared in this cycle.
  assign req_set  = evt.ep_access & ~req_kept;                        // see R7
  // Set wins over a firmware clear in the same cycle.
  assign req_next = req_kept | req_set;                               // see R6

  always_comb
  begin
    epf_d = wr_epf ? (req.wdata & ups_pkg::EPF_WMASK) : epf_q;        // see R8
    epf_d[ups_pkg::EPF_REQ_LO +: ups_pkg::NUM_EP] = req_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      epf_q <= ups_pkg::EPF_RST;                                      // see R9
    else
      epf_q <= epf_d;                                                 // see R10
  end

  wire legacy_mode = epf_q[ups_pkg::EPF_LEGACY] && !epf_q[ups_pkg::EPF_SERIAL];  // see R17
  wire serial_mode = !epf_q[ups_pkg::EPF_LEGACY] && epf_q[ups_pkg::EPF_SERIAL];  // see R17

  // --------------------------------------------------------------------------
  // System clock control
  // --------------------------------------------------------------------------
  logic [7:0] scc_q;
  logic [7:0] scc_d;

  always_comb
  begin
    scc_d = wr_scc ? (req.wdata & ups_pkg::SCC_WMASK) : scc_q;        // see R16
    if (serial_mode)
      scc_d[ups_pkg::SCC_DEEP_SUSP] = 1'b0;                           // see R13
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      scc_q <= ups_pkg::SCC_RST;                                      // see R12
    else
      scc_q <= scc_d;                                                 // see R14
  end

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  logic [7:0] bsc_view;
  logic [7:0] rdata_d;

  always_comb
  begin
    bsc_view = 8'h00;
    bsc_view[ups_pkg::BSC_SUSPEND]  = suspend_q;                      // see R1
    bsc_view[ups_pkg::BSC_RESET]    = reset_flag_q;
    bsc_view[ups_pkg::BSC_RESUME]   = resume_q;
    bsc_view[ups_pkg::BSC_DATA_IN]  = dat_s2_q[0] & data_out_q;       // see R18
    bsc_view[ups_pkg::BSC_CLOCK_IN] = dat_s2_q[1] & clock_out_q;      // see R18
  end

  assign rdata_d = !req.rd ? 8'h00 :
                   (req.addr == ups_pkg::BUS_STATUS_CONTROL_OFS)   ? bsc_view :
                   (req.addr == ups_pkg::ENDPOINT_FLAGS_OFS)       ? epf_q :   // see R11
                   (req.addr == ups_pkg::SYSTEM_CLOCK_CONTROL_OFS) ? scc_q :   // see R15
                   8'h00;

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  wire irq_d = irq_enable && !stack_full && ((|req_set) || suspend_rise);  // see R6

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata                  <= 8'h00;
      bus_irq                <= 1'b0;
      remote_wakeup_drive    <= 1'b0;
      kbd_data_oe            <= 1'b0;
      kbd_clock_oe           <= 1'b0;
      kbd_data_pin_out       <= 1'b0;
      kbd_clock_pin_out      <= 1'b0;
      engine_owns_pins       <= 1'b0;
      bus_clock_gate         <= 1'b0;
      deep_suspend           <= 1'b0;
      oscillator_rate_select <= 1'b0;
    end
    else
    begin
      rdata                  <= rdata_d;
      bus_irq                <= irq_d;                                // see R19
      remote_wakeup_drive    <= wr_bsc ? req.wdata[ups_pkg::BSC_WAKEUP] : wakeup_q;  // see R2
      // Open-drain style: drive low only when the output bit is 0.
      kbd_data_oe            <= legacy_mode && !data_out_q;           // see R17
      kbd_clock_oe           <= legacy_mode && !clock_out_q;          // see R17
      kbd_data_pin_out       <= data_out_q;                           // see R5
      kbd_clock_pin_out      <= clock_out_q;                          // see R5
      engine_owns_pins       <= serial_mode;                          // see R17
      bus_clock_gate         <= scc_q[ups_pkg::SCC_CLK_GATE];         // see R12
      deep_suspend           <= scc_q[ups_pkg::SCC_DEEP_SUSP];        // see R13
      oscillator_rate_select <= scc_q[ups_pkg::SCC_OSC_RATE];         // see R14
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_read_latency;
    @(posedge mclk) disable iff (!rstn)
    req.rd && req.addr == ups_pkg::SYSTEM_CLOCK_CONTROL_OFS |=> rdata == $past(scc_q);
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("clock register read wrong"); // see R15

  property p_reset_flag_set;
    @(posedge mclk) disable iff (!rstn)
    evt.bus_reset |=> reset_flag_q;
  endproperty
  a_reset_flag_set: assert property (p_reset_flag_set) else $error("reset flag not set"); // see R20

  property p_reset_flag_hold;
    @(posedge mclk) disable iff (!rstn)
    reset_flag_q && !wr_bsc |=> reset_flag_q;
  endproperty
  a_reset_flag_hold: assert property (p_reset_flag_hold) else $error("reset flag dropped"); // see R3

  property p_resume_set;
    @(posedge mclk) disable iff (!rstn)
    evt.resume |=> resume_q;
  endproperty
  a_resume_set: assert property (p_resume_set) else $error("resume not recorded"); // see R4

  property p_ep_set;
    @(posedge mclk) disable iff (!rstn)
    evt.ep_access[0] |=> epf_q[0];
  endproperty
  a_ep_set: assert property (p_ep_set) else $error("endpoint flag not set"); // see R6

  property p_ep_irq;
    @(posedge mclk) disable iff (!rstn)
    (|req_set) && irq_enable && !stack_full |=> bus_irq;
  endproperty
  a_ep_irq: assert property (p_ep_irq) else $error("endpoint interrupt missing"); // see R6

  property p_deep_blocked;
    @(posedge mclk) disable iff (!rstn)
    serial_mode |=> !scc_q[ups_pkg::SCC_DEEP_SUSP] ##1 !deep_suspend;
  endproperty
  a_deep_blocked: assert property (p_deep_blocked) else $error("deep suspend in bus mode"); // see R13

  property p_suspend_idle;
    @(posedge mclk) disable iff (!rstn)
    suspend_q |-> !$past(evt.bus_active);
  endproperty
  a_suspend_idle: assert property (p_suspend_idle) else $error("suspend while active"); // see R19

  property p_pin_gate;
    @(posedge mclk) disable iff (!rstn)
    !data_out_q |-> !bsc_view[ups_pkg::BSC_DATA_IN];
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("data input not gated"); // see R18

  property p_reserved_zero;
    @(posedge mclk) disable iff (!rstn)
    wr_scc |=> (scc_q & ~ups_pkg::SCC_WMASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved clock bits set"); // see R16

  property p_wake_follow;
    @(posedge mclk) disable iff (!rstn)
    wr_bsc |=> remote_wakeup_drive == $past(req.wdata[ups_pkg::BSC_WAKEUP]);
  endproperty
  a_wake_follow: assert property (p_wake_follow) else $error("wake-up drive wrong"); // see R2

  property p_port_release;
    @(posedge mclk) disable iff (!rstn)
    !legacy_mode |=> !kbd_data_oe && !kbd_clock_oe;
  endproperty
  a_port_release: assert property (p_port_release) else $error("port line driven"); // see R17

  property p_irq_gate;
    @(posedge mclk) disable iff (!rstn)
    bus_irq |-> $past(irq_enable) && !$past(stack_full);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while blocked"); // see R6

  property p_suspend_irq;
    @(posedge mclk) disable iff (!rstn)
    suspend_rise && irq_enable && !stack_full |=> bus_irq;
  endproperty
  a_suspend_irq: assert property (p_suspend_irq) else $error("suspend interrupt missing"); // see R19

  property p_ep_hold;
    @(posedge mclk) disable iff (!rstn)
    req_flags[0] && !wr_epf |=> req_flags[0];
  endproperty
  a_ep_hold: assert property (p_ep_hold) else $error("endpoint flag dropped"); // see R7

  property p_osc_follow;
    @(posedge mclk) disable iff (!rstn)
    scc_q[ups_pkg::SCC_OSC_RATE] |=> oscillator_rate_select;
  endproperty
  a_osc_follow: assert property (p_osc_follow) else $error("rate select not driven"); // see R14

endmodule // ups_status_ctrl

// ===== ups_host_model.sv
// Behavioural bus host that raises bus events and shares the keyboard lines.
`timescale 1ns/1ps
module ups_host_model (
  input  wire logic              mclk,
  input  wire logic              data_oe,
  input  wire logic              clock_oe,
  input  wire logic              data_out,
  input  wire logic              clock_out,
  output wire ups_pkg::ups_evt_t evt,
  output wire logic              data_pin,
  output wire logic              clock_pin
);
  logic       active   = 1'b1;
  logic [1:0] pull_low = 2'b00;
  logic       rst_p    = 1'b0;
  logic       res_p    = 1'b0;
  logic [2:0] ep_p     = 3'h0;

  // ------
  // Lines
  // ------
  // Both lines have pull-ups, so a released line reads high.
  assign data_pin  = (data_oe ? data_out : 1'b1) & ~pull_low[0];
  assign clock_pin = (clock_oe ? clock_out : 1'b1) & ~pull_low[1];
  assign evt       = '{active, rst_p, res_p, ep_p};

  // ------
  // Events
  // ------
  task automatic set_line(input logic act, input logic [1:0] low);
    @(posedge mclk);
    active   <= act;
    pull_low <= low;
  endtask

  task automatic pulse(input logic [4:0] which);
    @(posedge mclk);
    {rst_p, res_p, ep_p} <= which;
    @(posedge mclk);
    {rst_p, res_p, ep_p} <= 5'h00;
  endtask
endmodule // ups_host_model

// ===== test_ups_status_ctrl.sv
// Self-checking bench of the status, control and clock-select register bank.
`timescale 1ns/1ps
module test_ups_status_ctrl;
  logic              mclk       = 1'b0;
  logic              rstn       = 1'b0;
  ups_pkg::ups_req_t req        = '0;
  logic              irq_enable;
  logic              stack_full;
  ups_pkg::ups_evt_t evt;
  logic [7:0]        rdata;
  logic              bus_irq, wake, d_oe, c_oe, d_out, c_out, d_pin, c_pin;
  logic              owns, gate, deep, rate;
  logic [15:0]       notes[$];
  logic [15:0]       note;
  logic [15:0]       rnd     = 16'hbeaf;
  logic              rd_seen = 1'b0;
  int                errors  = 0;
  int                n_checks = 0;
  int                irq_n   = 0;
  int                i;

  ups_status_ctrl #(.IDLE_CYCLES(20)) u_ups_status_ctrl (
    .mclk(mclk), .rstn(rstn), .req(req), .rdata(rdata), .evt(evt),
    .irq_enable(irq_enable), .stack_full(stack_full), .bus_irq(bus_irq),
    .remote_wakeup_drive(wake), .kbd_data_pin_in(d_pin), .kbd_clock_pin_in(c_pin),
    .kbd_data_oe(d_oe), .kbd_clock_oe(c_oe), .kbd_data_pin_out(d_out),
    .kbd_clock_pin_out(c_out), .engine_owns_pins(owns), .bus_clock_gate(gate),
    .deep_suspend(deep), .oscillator_rate_select(rate));

  ups_host_model u_ups_host_model (
    .mclk(mclk), .data_oe(d_oe), .clock_oe(c_oe), .data_out(d_out),
    .clock_out(c_out), .evt(evt), .data_pin(d_pin), .clock_pin(c_pin));

  always #10 mclk = ~mclk;

  // ------
  // Helpers
  // ------
  function automatic logic [15:0] xs(input logic [15:0] x);
    logic [15:0] y;
    y = x ^ (x << 7);
    y = y ^ (y >> 9);
    return y ^ (y << 8);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (notes.size() != 0)
      errors++;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    req <= '{a, d, 1'b0, 1'b0};
  endtask

  // Notes the expected value and the mask of bits that are judged.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge mclk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    notes.push_back({e & m, m});
    @(posedge mclk);
    req <= '{a, 8'h00, 1'b0, 1'b0};
  endtask

  task automatic wait_irq(input int exp, input int lim);
    int k;
    for (k = 0; k < lim && irq_n != exp; k++)
      @(posedge mclk);
    #1;
    chk(8'(irq_n), 8'(exp));
    if (irq_n != exp)
      end_sim;
  endtask

  // ------
  // Monitor
  // ------
  always @(posedge mclk)
  begin
    if (bus_irq === 1'b1)
      irq_n++;
    if (rd_seen && notes.size() == 0)
      chk(rdata, 8'hxx);
    else if (rd_seen)
    begin
      note = notes.pop_front();
      chk(rdata & note[7:0], note[15:8]);
    end
    rd_seen <= req.rd;
  end

  initial
  begin
    #200000;
    errors++;
    end_sim;
  end

  // ------
  // Scenarios
  // ------
  initial
  begin
    irq_enable <= 1'b1;
    stack_full <= 1'b0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    rd(8'h1a, 8'h00, 8'h0f);
    rd(8'h1b, 8'h00, 8'hff);
    rd(8'h1c, 8'h00, 8'hff);
    step(2);
    chk({wake, d_oe, c_oe, owns, gate, deep, rate, 1'b0}, 8'h00);
    rd(8'h1a, 8'h30, 8'hff);
    $display("test reset done");

    wr(8'h1b, 8'hff);
    rd(8'h1b, 8'hb0, 8'hf8);
    step(2);
    chk({7'h00, owns}, 8'h00);
    wr(8'h1b, 8'h10);
    for (i = 0; i < 4; i++)
    begin
      rnd = xs(rnd);
      wr(8'h1c, rnd[7:0]);
      rd(8'h1c, rnd[7:0] & 8'hd8, 8'hff);
      step(2);
      chk({5'h00, gate, deep, rate}, {5'h00, rnd[3], rnd[4], rnd[6]});
    end
    wr(8'h1b, 8'h20);
    wr(8'h1c, 8'h18);
    rd(8'h1c, 8'h08, 8'hff);
    wr(8'h1d, 8'hff);
    rd(8'h1d, 8'h00, 8'hff);
    rd(8'h1c, 8'h08, 8'hff);
    step(2);
    chk({6'h00, owns, deep}, 8'h02);
    $display("test modes done");

    wr(8'h1b, 8'h10);
    wr(8'h1a, 8'h80);
    step(2);
    chk({4'h0, d_oe, c_oe, d_out, c_out}, 8'h09);
    u_ups_host_model.set_line(1'b1, 2'b10);
    step(4);
    rd(8'h1a, 8'h00, 8'hf0);
    u_ups_host_model.set_line(1'b1, 2'b00);
    step(4);
    rd(8'h1a, 8'h20, 8'hf0);
    wr(8'h1a, 8'hc2);
    u_ups_host_model.set_line(1'b1, 2'b01);
    step(4);
    chk({5'h00, wake, d_oe, c_oe}, 8'h04);
    rd(8'h1a, 8'h20, 8'hf2);
    u_ups_host_model.set_line(1'b1, 2'b00);
    wr(8'h1a, 8'hc0);
    $display("test lines done");

    for (i = 0; i < 3; i++)
    begin
      u_ups_host_model.pulse(5'(1 << i));
      wait_irq(i + 1, 10);
    end
    rd(8'h1b, 8'h17, 8'hff);
    u_ups_host_model.pulse(5'h01);
    step(6);
    chk(8'(irq_n), 8'h03);
    wr(8'h1b, 8'h10);
    rd(8'h1b, 8'h10, 8'hff);
    @(posedge mclk) stack_full <= 1'b1;
    u_ups_host_model.pulse(5'h02);
    step(6);
    chk(8'(irq_n), 8'h03);
    rd(8'h1b, 8'h12, 8'hff);
    @(posedge mclk) stack_full <= 1'b0;
    irq_enable <= 1'b0;
    u_ups_host_model.pulse(5'h04);
    step(6);
    chk(8'(irq_n), 8'h03);
    @(posedge mclk) irq_enable <= 1'b1;
    $display("test endpoints done");

    u_ups_host_model.pulse(5'h10);
    step(2);
    rd(8'h1a, 8'h04, 8'h0f);
    wr(8'h1a, 8'hc0);
    rd(8'h1a, 8'h00, 8'h0f);
    u_ups_host_model.set_line(1'b0, 2'b00);
    wait_irq(4, 60);
    rd(8'h1a, 8'h01, 8'h0f);
    u_ups_host_model.pulse(5'h08);
    step(2);
    rd(8'h1a, 8'h08, 8'h08);
    u_ups_host_model.set_line(1'b1, 2'b00);
    step(3);
    rd(8'h1a, 8'h00, 8'h0f);
    $display("test events done");
    step(3);
    end_sim;
  end
endmodule // test_ups_status_ctrl
